/* File: tlc_bit_sync.sv */
// Purpose: Two-stage synchroniser for a bus of independent level signals.
// Assumes: Each bit is a slow level; a multi-bit group is only coherent when held still.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module tlc_bit_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} tlc_sync_state_t;
	tlc_sync_state_t st_r;
	tlc_sync_state_t st_nxt;
	initial begin
		if (W < 1) $error("tlc_bit_sync needs W of at least 1");
	end
	always_comb begin
		st_nxt.s1 = async_i;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sync_o = st_r.s2;
endmodule

/* File: tlc_host_model.sv */
// Purpose: Host processor model that reaches the register bank over AXI4-Lite.
// Assumes: One outstanding write and one outstanding read at a time.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/100ps
module tlc_host_model
	import tlc_pkg::*;
(
	input wire logic ref_clk_i,
	output logic [tlc_pkg::ADDR_W-1:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic [3:0] wstrb_o,
	output logic wvalid_o,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [tlc_pkg::ADDR_W-1:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end
	// ============================================================
	// Bus cycles
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		@(posedge ref_clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		wstrb_o <= s;
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		for (int n = 0; n < 20 && awready_i !== 1'b1; n++) @(posedge ref_clk_i);
		{awvalid_o, wvalid_o} <= 2'h0;
		awaddr_o <= ~a;
		wdata_o <= ~d;
		for (int n = 0; n < 20 && bvalid_i !== 1'b1; n++) @(posedge ref_clk_i);
		resp = bresp_i;
		bready_o <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk_i);
		araddr_o <= a;
		{arvalid_o, rready_o} <= 2'h3;
		for (int n = 0; n < 20 && arready_i !== 1'b1; n++) @(posedge ref_clk_i);
		arvalid_o <= 1'b0;
		araddr_o <= ~a;
		for (int n = 0; n < 20 && rvalid_i !== 1'b1; n++) @(posedge ref_clk_i);
		d = rdata_i;
		resp = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule

/* File: tlc_pkg.sv */
// Purpose: Shared constants and types for the transmit link configuration register bank.
// Assumes: A 32-bit AXI4-Lite register port with 12 byte-address bits.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package tlc_pkg;
	// ============================================================
	// Register offsets
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_LINK_RATE = 12'h000;
	localparam logic [11:0] OFF_LANE_TOTAL = 12'h004;
	localparam logic [11:0] OFF_FRAMING = 12'h008;
	localparam logic [11:0] OFF_TRAIN = 12'h00c;
	localparam logic [11:0] OFF_QUALITY = 12'h010;
	localparam logic [11:0] OFF_SCR_BYPASS = 12'h014;
	localparam logic [11:0] OFF_SOFT_RESET = 12'h01c;
	localparam logic [11:0] OFF_CUSTOM_LOW = 12'h020;
	localparam logic [11:0] OFF_CUSTOM_MID = 12'h024;
	localparam logic [11:0] OFF_CUSTOM_HIGH = 12'h028;
	localparam logic [11:0] OFF_SENDER_EN = 12'h080;
	localparam logic [11:0] OFF_STREAM_EN = 12'h084;
	localparam logic [11:0] OFF_LINK_STATUS = 12'h090;
	localparam logic [11:0] OFF_STATUS_HOLD = 12'h094;
	localparam logic [11:0] OFF_SCR_RESTART = 12'h0c0;
	localparam logic [11:0] OFF_MULTISTREAM = 12'h0d0;
	// ============================================================
	// Field positions and widths
	localparam int BIT_ENABLE = 0;
	localparam int BIT_VIDEO_RST = 0;
	localparam int BIT_AUX_RST = 7;
	localparam int BIT_MST_EN = 0;
	localparam int BIT_PAYLOAD_UPD = 1;
	localparam int BIT_STAT_STREAM = 0;
	localparam int POS_STAT_FIELD = 8;
	localparam int W_RATE = 8;
	localparam int W_LANE = 5;
	localparam int W_SEL = 3;
	localparam int W_CUST_HI = 16;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// ============================================================
	// Code points
	localparam logic [7:0] RATE_1G62 = 8'h06;
	localparam logic [7:0] RATE_2G7 = 8'h0a;
	localparam logic [7:0] RATE_5G4 = 8'h14;
	localparam logic [7:0] RATE_8G1 = 8'h1e;
	localparam logic [2:0] TRAIN_OFF = 3'h0;
	localparam logic [2:0] TRAIN_PAT1 = 3'h1;
	localparam logic [2:0] TRAIN_PAT2 = 3'h2;
	localparam logic [2:0] TRAIN_PAT3 = 3'h3;
	localparam logic [2:0] TRAIN_PAT4 = 3'h7;
	localparam logic [2:0] QUAL_NONE = 3'h0;
	localparam logic [2:0] QUAL_D10_2 = 3'h1;
	localparam logic [2:0] QUAL_SER = 3'h2;
	localparam logic [2:0] QUAL_PRBS7 = 3'h3;
	localparam logic [2:0] QUAL_CUSTOM = 3'h4;
	localparam logic [2:0] QUAL_COMPLY = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ============================================================
	// Configuration bundle handed to the link and video logic
	typedef struct packed {
		logic [7:0] link_rate;
		logic [4:0] lane_total;
		logic enhanced_framing;
		logic [2:0] train_sel;
		logic [2:0] quality_sel;
		logic scrambler_bypass;
		logic [79:0] custom_pattern;
		logic sender_enable;
		logic mst_enable;
	} tlc_cfg_t;
endpackage

/* File: tlc_pulse_gen.sv */
// Purpose: Self-clearing pulse of fixed length started by a one-cycle request.
// Assumes: The request comes from logic on the same clock.
// Notes: The length is stretched so slower consumer domains can catch the pulse.
`timescale 1ns/100ps
module tlc_pulse_gen #(
	parameter int LEN = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic pulse_o
);
	localparam int CNT_W = $clog2(LEN + 1);
	typedef struct packed {
		logic active;
		logic [CNT_W-1:0] cnt;
	} tlc_pulse_state_t;
	tlc_pulse_state_t st_r;
	tlc_pulse_state_t st_nxt;
	initial begin
		if (LEN < 1) $error("tlc_pulse_gen needs LEN of at least 1");
	end
	always_comb begin
		st_nxt = st_r;
		if (start_i) begin
			st_nxt.active = 1'b1;
			st_nxt.cnt = CNT_W'(LEN - 1);
		end else if (st_r.active) begin
			if (st_r.cnt == '0) begin
				st_nxt.active = 1'b0;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pulse_o = st_r.active;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_pulse_start: assert property (start_i |=> pulse_o)
		else $error("pulse did not start after request");
	a_pulse_end: assert property ($fell(pulse_o) |-> $past(st_r.cnt) == '0)
		else $error("pulse ended before its length");
endmodule

/* File: tlc_regs.sv */
// Purpose: Host-programmed configuration and enable register bank of a serial video sender.
// Assumes: AXI4-Lite slave on ref_clk_i; link and video logic sit in other clock domains.
// Notes: One write and one read may be in flight at a time.
// Overview of operation
// - All registers sit on the host port, live in host clock, other domains async.
// - A single status bit reads as either its old or new value.
// - A hold bit freezes the multi-bit status field while software reads it.
// - A toggle flips on every multi-bit configuration write to refresh remote copies.
// - Undefined bits are reserved and read as zero.
// - Every register is zero after power-on reset; the video absent flag resets to one.
// - Eight-bit link rate codes 06, 0A, 14, 1E select four link rates.
// - Framing bit zero enables the enhanced framing symbol sequence.
// - Training selector codes off, pattern 1, and patterns 2, 3, 4.
// - Quality selector codes none, D10.2, error rate, PRBS7, custom, compliance.
// - Scrambler bypass bit zero sends every symbol unscrambled.
// - Soft reset bit zero resets stream one video logic; register reads zero.
// - Soft reset bit seven resets the auxiliary channel logic.
// - Custom 80-bit pattern spans low, middle and 16-bit high words.
// - Sender enable low sends only stuffing symbols; high lets streams flow.
// - Stream disabled sends only the blanking identifier with video absent flag set.
// - Stream enable changes take effect only at a vertical sync frame boundary.
// - Restart bit zero forces a scrambler reset; register reads zero.
// - Multi-stream bit zero enables multi-stream transport operation.
`timescale 1ns/100ps
module tlc_regs
	import tlc_pkg::*;
#(
	parameter int STAT_W = 8,
	parameter int PULSE_LEN = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [tlc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [tlc_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic vsync_i,
	input wire logic [STAT_W-1:0] link_status_i,
	output tlc_pkg::tlc_cfg_t cfg_o,
	output logic cfg_toggle_o,
	output logic stream_enable_o,
	output logic video_absent_flag_o,
	output logic video_rst_o,
	output logic aux_rst_o,
	output logic scr_restart_o,
	output logic payload_updated_o
);
	import tlc_pkg::*;

	// ============================================================
	// State
	typedef struct packed {
		logic wr_ack;
		logic bvalid;
		logic [1:0] bresp;
		logic rd_ack;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		tlc_cfg_t cfg;
		logic stream_req;
		logic stream_act;
		logic video_absent;
		logic vsync_prev;
		logic cfg_toggle;
		logic status_hold;
		logic [STAT_W-1:0] status_cap;
	} tlc_regs_state_t;

	tlc_regs_state_t st_r;
	tlc_regs_state_t st_nxt;
	logic vsync_s;
	logic [STAT_W-1:0] status_s;
	logic vs_rise;
	logic video_go;
	logic aux_go;
	logic scr_go;
	logic upd_go;
	logic [11:0] wa;
	logic [11:0] ra;
	logic [31:0] wmix;

	initial begin
		if (STAT_W < 1 || STAT_W > 16) $error("tlc_regs needs STAT_W from 1 to 16");
	end

	function automatic logic [31:0] byte_merge(input logic [31:0] old,
			input logic [31:0] din, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = din[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ============================================================
	// Crossings from the video and link domains
	tlc_bit_sync #(
		.W(1)
	) u_vsync_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(vsync_i),
		.sync_o(vsync_s)
	);

	tlc_bit_sync #(
		.W(STAT_W)
	) u_status_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(link_status_i),
		.sync_o(status_s)
	);

	// Word-aligned addresses; the two low bits never select a register.
	assign wa = {s_axi_awaddr_i[11:2], 2'h0};
	assign ra = {s_axi_araddr_i[11:2], 2'h0};
	assign vs_rise = vsync_s & ~st_r.vsync_prev;

	// ============================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		video_go = 1'b0;
		aux_go = 1'b0;
		scr_go = 1'b0;
		upd_go = 1'b0;
		wmix = ZERO32;

		// Write channel: address and data are taken together, one at a time.
		if (st_r.bvalid && s_axi_bready_i) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.wr_ack) begin
			st_nxt.wr_ack = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (wa)
				OFF_LINK_RATE: begin
					wmix = byte_merge(32'(st_r.cfg.link_rate), s_axi_wdata_i, s_axi_wstrb_i);
					st_nxt.cfg.link_rate = wmix[W_RATE-1:0];
					st_nxt.cfg_toggle = ~st_r.cfg_toggle;
				end
				OFF_LANE_TOTAL: begin
					wmix = byte_merge(32'(st_r.cfg.lane_total), s_axi_wdata_i, s_axi_wstrb_i);
					st_nxt.cfg.lane_total = wmix[W_LANE-1:0];
					st_nxt.cfg_toggle = ~st_r.cfg_toggle;
				end
				OFF_FRAMING: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.enhanced_framing = s_axi_wdata_i[BIT_ENABLE];
					end
				end
				OFF_TRAIN: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.train_sel = s_axi_wdata_i[W_SEL-1:0];
						st_nxt.cfg_toggle = ~st_r.cfg_toggle;
					end
				end
				OFF_QUALITY: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.quality_sel = s_axi_wdata_i[W_SEL-1:0];
						st_nxt.cfg_toggle = ~st_r.cfg_toggle;
					end
				end
				OFF_SCR_BYPASS: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.scrambler_bypass = s_axi_wdata_i[BIT_ENABLE];
					end
				end
				OFF_SOFT_RESET: begin
					video_go = s_axi_wstrb_i[0] & s_axi_wdata_i[BIT_VIDEO_RST];
					aux_go = s_axi_wstrb_i[0] & s_axi_wdata_i[BIT_AUX_RST];
				end
				OFF_CUSTOM_LOW: begin
					st_nxt.cfg.custom_pattern[31:0] = byte_merge(
						st_r.cfg.custom_pattern[31:0], s_axi_wdata_i, s_axi_wstrb_i);
					st_nxt.cfg_toggle = ~st_r.cfg_toggle;
				end
				OFF_CUSTOM_MID: begin
					st_nxt.cfg.custom_pattern[63:32] = byte_merge(
						st_r.cfg.custom_pattern[63:32], s_axi_wdata_i, s_axi_wstrb_i);
					st_nxt.cfg_toggle = ~st_r.cfg_toggle;
				end
				OFF_CUSTOM_HIGH: begin
					wmix = byte_merge(32'(st_r.cfg.custom_pattern[79:64]),
						s_axi_wdata_i, s_axi_wstrb_i);
					st_nxt.cfg.custom_pattern[79:64] = wmix[W_CUST_HI-1:0];
					st_nxt.cfg_toggle = ~st_r.cfg_toggle;
				end
				OFF_SENDER_EN: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.sender_enable = s_axi_wdata_i[BIT_ENABLE];
					end
				end
				OFF_STREAM_EN: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.stream_req = s_axi_wdata_i[BIT_ENABLE];
					end
				end
				OFF_LINK_STATUS: begin
				end
				OFF_STATUS_HOLD: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.status_hold = s_axi_wdata_i[BIT_ENABLE];
					end
				end
				OFF_SCR_RESTART: begin
					scr_go = s_axi_wstrb_i[0] & s_axi_wdata_i[BIT_ENABLE];
				end
				OFF_MULTISTREAM: begin
					if (s_axi_wstrb_i[0]) begin
						st_nxt.cfg.mst_enable = s_axi_wdata_i[BIT_MST_EN];
						upd_go = s_axi_wdata_i[BIT_PAYLOAD_UPD];
					end
				end
				default: begin
					st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end else if (s_axi_awvalid_i && s_axi_wvalid_i && !st_r.bvalid) begin
			st_nxt.wr_ack = 1'b1;
		end

		// Read channel: the data word is captured in the accept cycle.
		if (st_r.rvalid && s_axi_rready_i) begin
			st_nxt.rvalid = 1'b0;
		end
		if (st_r.rd_ack) begin
			st_nxt.rd_ack = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = ZERO32;
			case (ra)
				OFF_LINK_RATE: st_nxt.rdata[W_RATE-1:0] = st_r.cfg.link_rate;
				OFF_LANE_TOTAL: st_nxt.rdata[W_LANE-1:0] = st_r.cfg.lane_total;
				OFF_FRAMING: st_nxt.rdata[BIT_ENABLE] = st_r.cfg.enhanced_framing;
				OFF_TRAIN: st_nxt.rdata[W_SEL-1:0] = st_r.cfg.train_sel;
				OFF_QUALITY: st_nxt.rdata[W_SEL-1:0] = st_r.cfg.quality_sel;
				OFF_SCR_BYPASS: st_nxt.rdata[BIT_ENABLE] = st_r.cfg.scrambler_bypass;
				OFF_SOFT_RESET: st_nxt.rdata = ZERO32;
				OFF_CUSTOM_LOW: st_nxt.rdata = st_r.cfg.custom_pattern[31:0];
				OFF_CUSTOM_MID: st_nxt.rdata = st_r.cfg.custom_pattern[63:32];
				OFF_CUSTOM_HIGH: st_nxt.rdata[W_CUST_HI-1:0] = st_r.cfg.custom_pattern[79:64];
				OFF_SENDER_EN: st_nxt.rdata[BIT_ENABLE] = st_r.cfg.sender_enable;
				OFF_STREAM_EN: st_nxt.rdata[BIT_ENABLE] = st_r.stream_req;
				OFF_LINK_STATUS: begin
					// Each bit is one registered sample, so the stream bit never reads a half value; the field bits may mix old and new.
					st_nxt.rdata[BIT_STAT_STREAM] = st_r.stream_act;
					st_nxt.rdata[POS_STAT_FIELD +: STAT_W] = st_r.status_cap;
				end
				OFF_STATUS_HOLD: st_nxt.rdata[BIT_ENABLE] = st_r.status_hold;
				OFF_SCR_RESTART: st_nxt.rdata = ZERO32;
				OFF_MULTISTREAM: st_nxt.rdata[BIT_MST_EN] = st_r.cfg.mst_enable;
				default: st_nxt.rresp = RESP_SLVERR;
			endcase
		end else if (s_axi_arvalid_i && !st_r.rvalid) begin
			st_nxt.rd_ack = 1'b1;
		end

		// A new enable waits for the next frame start so no frame is cut in two.
		st_nxt.vsync_prev = vsync_s;
		if (vs_rise) begin
			st_nxt.stream_act = st_r.stream_req;
		end
		st_nxt.video_absent = ~st_nxt.stream_act;

		if (!st_r.status_hold) begin
			st_nxt.status_cap = status_s;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.video_absent <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// Self-clearing control pulses
	tlc_pulse_gen #(
		.LEN(PULSE_LEN)
	) u_video_rst (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(video_go),
		.pulse_o(video_rst_o)
	);

	tlc_pulse_gen #(
		.LEN(PULSE_LEN)
	) u_aux_rst (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(aux_go),
		.pulse_o(aux_rst_o)
	);

	tlc_pulse_gen #(
		.LEN(PULSE_LEN)
	) u_scr_restart (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(scr_go),
		.pulse_o(scr_restart_o)
	);

	tlc_pulse_gen #(
		.LEN(PULSE_LEN)
	) u_payload_upd (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(upd_go),
		.pulse_o(payload_updated_o)
	);

	// ============================================================
	// Outputs
	assign s_axi_awready_o = st_r.wr_ack;
	assign s_axi_wready_o = st_r.wr_ack;
	assign s_axi_bvalid_o = st_r.bvalid;
	assign s_axi_bresp_o = st_r.bresp;
	assign s_axi_arready_o = st_r.rd_ack;
	assign s_axi_rvalid_o = st_r.rvalid;
	assign s_axi_rresp_o = st_r.rresp;
	assign s_axi_rdata_o = st_r.rdata;
	assign cfg_o = st_r.cfg;
	assign cfg_toggle_o = st_r.cfg_toggle;
	assign stream_enable_o = st_r.stream_act;
	assign video_absent_flag_o = st_r.video_absent;

	// ============================================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_write_resp: assert property (st_r.wr_ack |=> s_axi_bvalid_o && !s_axi_awready_o)
		else $error("write accept not answered next cycle");
	a_reset_zero: assert property ($past(rst_i) |-> cfg_o == '0 && !stream_enable_o)
		else $error("configuration not zero after reset");
	a_reserved_zero: assert property (st_r.rd_ack && ra == OFF_FRAMING
		|=> s_axi_rvalid_o && s_axi_rdata_o[31:1] == 31'h0000_0000)
		else $error("reserved bits read nonzero");
	a_soft_readzero: assert property (st_r.rd_ack && ra == OFF_SOFT_RESET
		|=> s_axi_rvalid_o && s_axi_rdata_o == ZERO32)
		else $error("soft reset register read nonzero");
	a_video_pulse: assert property (st_r.wr_ack && wa == OFF_SOFT_RESET
		&& s_axi_wstrb_i[0] && s_axi_wdata_i[BIT_VIDEO_RST] |=> ##1 video_rst_o)
		else $error("video reset pulse missing");
	a_aux_pulse: assert property (st_r.wr_ack && wa == OFF_SOFT_RESET
		&& s_axi_wstrb_i[0] && s_axi_wdata_i[BIT_AUX_RST] |=> ##1 aux_rst_o)
		else $error("aux reset pulse missing");
	a_scr_pulse: assert property (st_r.wr_ack && wa == OFF_SCR_RESTART
		&& s_axi_wstrb_i[0] && s_axi_wdata_i[BIT_ENABLE] |=> ##1 scr_restart_o)
		else $error("scrambler restart pulse missing");
	a_toggle_flip: assert property (st_r.wr_ack && wa == OFF_LINK_RATE
		|=> cfg_toggle_o != $past(cfg_toggle_o))
		else $error("refresh toggle did not flip");
	a_sender_write: assert property (st_r.wr_ack && wa == OFF_SENDER_EN && s_axi_wstrb_i[0]
		|=> cfg_o.sender_enable == $past(s_axi_wdata_i[BIT_ENABLE]))
		else $error("sender enable not written");
	a_mst_write: assert property (st_r.wr_ack && wa == OFF_MULTISTREAM && s_axi_wstrb_i[0]
		|=> cfg_o.mst_enable == $past(s_axi_wdata_i[BIT_MST_EN]))
		else $error("multi-stream enable not written");
	a_stream_frame: assert property ($changed(stream_enable_o) |-> $past(vs_rise))
		else $error("stream enable changed mid-frame");
	a_absent_flag: assert property (##1 video_absent_flag_o == !stream_enable_o)
		else $error("video absent flag disagrees with stream enable");
	a_hold_stable: assert property (st_r.status_hold && $past(st_r.status_hold)
		|-> $stable(st_r.status_cap))
		else $error("held status field changed");

	c_write: cover property (st_r.wr_ack ##1 s_axi_bvalid_o && s_axi_bready_i);
	c_read: cover property (st_r.rd_ack ##1 s_axi_rvalid_o && s_axi_rready_i);
	c_stream_apply: cover property (vs_rise && st_r.stream_req && !st_r.stream_act);
	c_soft_reset: cover property ($rose(video_rst_o));
endmodule

/* File: tlc_tb.sv */
// Purpose: Self-checking bench for the transmit link configuration register bank.
// Assumes: The host model performs every bus cycle.
// Notes: Pulse lengths are judged by counting high cycles over a fixed span.
`timescale 1ns/100ps
module tb;
	import tlc_pkg::*;
	localparam int PL = 4;
	logic ref_clk_i, rst_i, vsync, cfg_toggle, stream_en, absent;
	logic video_rst, aux_rst, scr_restart, payload_upd;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] link_status;
	tlc_cfg_t cfg;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	tlc_regs #(.STAT_W(8), .PULSE_LEN(PL)) tlc_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .vsync_i(vsync),
		.link_status_i(link_status), .cfg_o(cfg), .cfg_toggle_o(cfg_toggle),
		.stream_enable_o(stream_en), .video_absent_flag_o(absent), .video_rst_o(video_rst),
		.aux_rst_o(aux_rst), .scr_restart_o(scr_restart), .payload_updated_o(payload_upd));
	tlc_host_model tlc_host_model_i (.ref_clk_i(ref_clk_i), .awaddr_o(awaddr),
		.awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
		.wvalid_o(wvalid), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
		.araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
	// ============================================================
	// Clock, timeout and shared tasks
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		tlc_host_model_i.wr(a, d, 4'hf, r);
		cmp($sformatf("bresp %h", a), {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic [1:0] r;
		tlc_host_model_i.rd(a, d, r);
		cmp($sformatf("rresp %h", a), {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		cmp($sformatf("rdata %h", a), e, d);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset();
		logic [11:0] offs [14] = '{OFF_LINK_RATE, OFF_LANE_TOTAL, OFF_FRAMING, OFF_TRAIN,
			OFF_QUALITY, OFF_SCR_BYPASS, OFF_SOFT_RESET, OFF_CUSTOM_LOW, OFF_CUSTOM_MID,
			OFF_CUSTOM_HIGH, OFF_SENDER_EN, OFF_STREAM_EN, OFF_SCR_RESTART, OFF_MULTISTREAM};
		logic [31:0] d;
		logic [1:0] r;
		cmp("cfg_o", ZERO32, {31'h0, |cfg});
		cmp("video_absent_flag_o", 32'h1, {31'h0, absent});
		for (int i = 0; i < 14; i++) rd_chk(offs[i], ZERO32);
		tlc_host_model_i.rd(12'h0e0, d, r);
		cmp("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		cmp("unmapped rdata", ZERO32, d);
		tlc_host_model_i.wr(12'h0e0, 32'hffff_ffff, 4'hf, r);
		cmp("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask
	task automatic t_fields();
		logic [11:0] offs [10] = '{OFF_LINK_RATE, OFF_LANE_TOTAL, OFF_FRAMING, OFF_TRAIN,
			OFF_QUALITY, OFF_SCR_BYPASS, OFF_CUSTOM_LOW, OFF_CUSTOM_MID, OFF_CUSTOM_HIGH,
			OFF_SENDER_EN};
		logic [31:0] mask [10] = '{32'h0000_00ff, 32'h0000_001f, 32'h0000_0001, 32'h0000_0007,
			32'h0000_0007, 32'h0000_0001, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff, 32'h0000_0001};
		logic [9:0] flips = 10'h1db;
		logic [2:0] tr [5] = '{TRAIN_OFF, TRAIN_PAT1, TRAIN_PAT2, TRAIN_PAT3, TRAIN_PAT4};
		logic [2:0] ql [6] = '{QUAL_NONE, QUAL_D10_2, QUAL_SER, QUAL_PRBS7, QUAL_CUSTOM, QUAL_COMPLY};
		logic [7:0] rt [4] = '{RATE_1G62, RATE_2G7, RATE_5G4, RATE_8G1};
		logic t;
		logic [1:0] r;
		for (int i = 0; i < 10; i++) begin
			t = cfg_toggle;
			wr(offs[i], 32'hffff_ffff);
			cmp("cfg_toggle_o", {31'h0, t ^ flips[i]}, {31'h0, cfg_toggle});
			rd_chk(offs[i], mask[i]);
		end
		cmp("single bits", 32'h7, {29'h0, cfg.enhanced_framing, cfg.scrambler_bypass,
			cfg.sender_enable});
		wr(OFF_FRAMING, ZERO32);
		wr(OFF_SCR_BYPASS, ZERO32);
		wr(OFF_SENDER_EN, ZERO32);
		cmp("single bits", ZERO32, {29'h0, cfg.enhanced_framing, cfg.scrambler_bypass,
			cfg.sender_enable});
		// A strobe on byte lane zero only must leave the upper three bytes alone.
		tlc_host_model_i.wr(OFF_CUSTOM_LOW, ZERO32, 4'h1, r);
		rd_chk(OFF_CUSTOM_LOW, 32'hffff_ff00);
		wr(OFF_CUSTOM_HIGH, 32'hdead_1234);
		rd_chk(OFF_CUSTOM_HIGH, 32'h0000_1234);
		cmp("custom_pattern", 32'h1234_ffff, cfg.custom_pattern[79:48]);
		cmp("custom_pattern", 32'hffff_ff00, cfg.custom_pattern[31:0]);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_LINK_RATE, {24'h0, rt[i]});
			cmp("link_rate", {24'h0, rt[i]}, {24'h0, cfg.link_rate});
		end
		for (int i = 0; i < 3; i++) begin
			wr(OFF_LANE_TOTAL, 32'h1 << i);
			cmp("lane_total", 32'h1 << i, {27'h0, cfg.lane_total});
		end
		for (int i = 0; i < 5; i++) begin
			wr(OFF_TRAIN, {29'h0, tr[i]});
			cmp("train_sel", {29'h0, tr[i]}, {29'h0, cfg.train_sel});
		end
		for (int i = 0; i < 6; i++) begin
			wr(OFF_QUALITY, {29'h0, ql[i]});
			cmp("quality_sel", {29'h0, ql[i]}, {29'h0, cfg.quality_sel});
		end
	endtask
	task automatic pulses(input logic [3:0] e);
		int c [4] = '{0, 0, 0, 0};
		repeat (12) begin
			c[0] += (video_rst === 1'b1);
			c[1] += (aux_rst === 1'b1);
			c[2] += (scr_restart === 1'b1);
			c[3] += (payload_upd === 1'b1);
			@(posedge ref_clk_i);
		end
		cmp("video_rst_o", e[0] ? PL : 0, c[0]);
		cmp("aux_rst_o", e[1] ? PL : 0, c[1]);
		cmp("scr_restart_o", e[2] ? PL : 0, c[2]);
		cmp("payload_updated_o", e[3] ? PL : 0, c[3]);
	endtask
	task automatic t_pulses();
		wr(OFF_SOFT_RESET, 32'h0000_0081);
		pulses(4'h3);
		rd_chk(OFF_SOFT_RESET, ZERO32);
		wr(OFF_SCR_RESTART, 32'h0000_0001);
		pulses(4'h4);
		rd_chk(OFF_SCR_RESTART, ZERO32);
		wr(OFF_MULTISTREAM, 32'h0000_0003);
		pulses(4'h8);
		rd_chk(OFF_MULTISTREAM, 32'h0000_0001);
		cmp("mst_enable", 32'h1, {31'h0, cfg.mst_enable});
	endtask
	task automatic t_stream();
		logic [31:0] d;
		for (int i = 1; i >= 0; i--) begin
			wr(OFF_STREAM_EN, i);
			repeat (8) @(posedge ref_clk_i);
			cmp("stream_enable_o", 1 - i, {31'h0, stream_en});
			vsync <= 1'b1;
			repeat (5) @(posedge ref_clk_i);
			cmp("stream_enable_o", i, {31'h0, stream_en});
			cmp("video_absent_flag_o", 1 - i, {31'h0, absent});
			rd(OFF_LINK_STATUS, d);
			cmp("status stream bit", i, {31'h0, d[0]});
			vsync <= 1'b0;
		end
	endtask
	task automatic t_hold();
		logic [31:0] d;
		logic [7:0] seq [3] = '{8'h5a, 8'h5a, 8'ha5};
		link_status <= 8'h5a;
		for (int i = 0; i < 3; i++) begin
			repeat (6) @(posedge ref_clk_i);
			rd(OFF_STATUS_HOLD - 12'h004, d);
			cmp("status field", {24'h0, seq[i]}, {24'h0, d[15:8]});
			wr(OFF_STATUS_HOLD, i == 0);
			link_status <= 8'ha5;
		end
	endtask
	// ============================================================
	// Main sequence
	initial begin
		rst_i = 1'b1;
		vsync = 1'b0;
		link_status = 8'h00;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_fields();
		t_pulses();
		t_stream();
		t_hold();
		give_verdict();
	end
endmodule
